// [rtl/wdt_pkg.sv]
// Shared constants for the watchdog timer block
package wdt_pkg;

    // Special function register bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets on the special function register bus
    localparam logic [7:0] RESTART_KEY_ADDR = 8'ha6;
    localparam logic [7:0] PERIOD_SEL_ADDR  = 8'ha7;

    // Restart key bytes, first then second
    localparam logic [7:0] KEY_FIRST  = 8'h1e;
    localparam logic [7:0] KEY_SECOND = 8'he1;

    // Timeout select field of the period register
    localparam int         SEL_LSB = 0;
    localparam int         SEL_W   = 3;
    localparam logic [2:0] SEL_RST = 3'h0;

    // Counter chain: base counter plus prescaler stage
    localparam int BASE_W  = 14;
    localparam int PRESC_W = 7;
    localparam int TOTAL_W = BASE_W + PRESC_W;

    // Oscillator periods per machine cycle
    localparam int         MC_DIV_W       = 4;
    localparam logic [3:0] MC_OSC_PERIODS = 4'hc;

    // Reset pulse length in oscillator periods
    localparam int         PULSE_W       = 7;
    localparam logic [6:0] RST_PULSE_OSC = 7'h60;

endpackage

// [rtl/restart_key_detect.sv]
// Two-write restart key sequence detector
module restart_key_detect (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // Abort any half-seen key
    input  wire logic                       clear_i,
    // Writes to the restart register only
    input  wire logic                       wr_i,
    input  wire logic [wdt_pkg::DATA_W-1:0] wdata_i,
    // One-cycle pulse per completed key
    output logic                            key_ok_o
);
    import wdt_pkg::*;

    // Gray order: idle, first byte seen
    typedef enum logic {
        KEY_IDLE  = 1'b0,
        KEY_ARMED = 1'b1
    } key_state_t;

    key_state_t state_q;    // Sequence position
    logic       key_ok_q;   // Registered key pulse

    // R17: sequence tracking
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= KEY_IDLE;
        end else if (clear_i) begin
            state_q <= KEY_IDLE;
        end else if (wr_i) begin
            unique case (state_q)
                KEY_IDLE: begin
                    // Only the first byte arms
                    if (wdata_i == KEY_FIRST) begin
                        state_q <= KEY_ARMED;
                    end
                end
                KEY_ARMED: begin
                    // A repeated first byte keeps us armed
                    if (wdata_i != KEY_FIRST) begin
                        state_q <= KEY_IDLE;
                    end
                end
            endcase
        end
    end

    // R1: key complete pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            key_ok_q <= 1'b0;
        end else begin
            key_ok_q <= !clear_i && wr_i && (state_q == KEY_ARMED)
                        && (wdata_i == KEY_SECOND);
        end
    end

    assign key_ok_o = key_ok_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_key_completes: assert property ( // R17
        (state_q == KEY_ARMED) && wr_i && !clear_i && (wdata_i == KEY_SECOND)
        |=> key_ok_o ##1 !key_ok_o)
        else $error("Second key byte after first did not pulse key");
    a_key_needs_arm: assert property ( // R17
        key_ok_o |-> $past(state_q) == KEY_ARMED && $past(wdata_i) == KEY_SECOND)
        else $error("Key pulse without armed first byte");
endmodule

// [rtl/reset_pulse_gen.sv]
// Fixed-length reset pin pulse generator
module reset_pulse_gen (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Start request, one cycle
    input  wire logic start_i,
    // Reset pin drive, high during pulse
    output logic      pulse_o
);
    import wdt_pkg::*;

    logic [PULSE_W-1:0] remain_q;   // Oscillator periods left
    logic               pulse_q;    // Pin drive flop

    // R8: period countdown
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            remain_q <= '0;
        end else if (start_i) begin
            remain_q <= RST_PULSE_OSC;
        end else if (remain_q != '0) begin
            remain_q <= remain_q - 1'b1;
        end
    end

    // R8: pin drive from the count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= start_i || (remain_q > 7'h01);
        end
    end

    assign pulse_o = pulse_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_pulse_idle: assert property ( // R8
        (remain_q == '0) && !start_i |=> !pulse_o)
        else $error("Reset pin driven with no pulse pending");
endmodule

// [rtl/watchdog_timer.sv]
// Watchdog timer core: key restart, timeout select and reset pulse
//
// Overview of operation
// R1: Software enables by writing 1E then E1
// R2: Each completed key clears the count
// R3: Base count overflow at 16383 resets device
// R4: Count advances once per machine cycle
// R5: Software restarts within 16383 machine cycles
// R6: Restart register is write-only, reads zero
// R7: Count is neither readable nor writable
// R8: Overflow drives a 96-period reset pulse
// R9: Seven-bit prescaler stage extends the counter
// R10: Select field n picks 2^(14+n)-1 timeout
// R11: Software leaves period bits 7:3 untouched
// R12: Select field reads zero after reset
// R13: Restart from periodic, reliable code paths
// R14: Watchdog disabled after any reset
// R15: Once running, software cannot stop it
// R16: Counting stops in power-down
// R17: E1 must directly follow a 1E write
module watchdog_timer (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // Special function register bus from the core
    input  wire logic [wdt_pkg::ADDR_W-1:0] sfr_addr_i,
    input  wire logic                       sfr_wr_i,
    input  wire logic                       sfr_rd_i,
    input  wire logic [wdt_pkg::DATA_W-1:0] sfr_wdata_i,
    output logic      [wdt_pkg::DATA_W-1:0] sfr_rdata_o,
    // Power control from the core
    input  wire logic                       power_down_i,
    // Reset pin drive and run status
    output logic                            reset_pin_o,
    output logic                            running_o
);
    import wdt_pkg::*;

    // Machine cycle divider
    logic [MC_DIV_W-1:0] mc_div_q;     // Oscillator period count
    logic                mc_tick_q;    // One-cycle machine cycle enable

    // Watchdog state
    logic                en_q;         // Watchdog running
    logic [TOTAL_W-1:0]  count_q;      // Base counter plus prescaler
    logic [SEL_W-1:0]    sel_q;        // Timeout select field
    logic [TOTAL_W-1:0]  limit_w;      // Terminal count for selection
    logic                ovf_w;        // Overflow this cycle

    // Register bus decode
    logic                key_wr_w;     // Write to restart register
    logic                sel_wr_w;     // Write to period register
    logic                key_ok_w;     // Completed key pulse
    logic [DATA_W-1:0]   rdata_q;      // Registered read data

    // Decode of the two mapped addresses
    assign key_wr_w = sfr_wr_i && (sfr_addr_i == RESTART_KEY_ADDR);
    assign sel_wr_w = sfr_wr_i && (sfr_addr_i == PERIOD_SEL_ADDR);

    // Key byte sequence checker
    // Our own overflow aborts a half-entered key as a reset would
    restart_key_detect u_key (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (ovf_w),
        .wr_i     (key_wr_w),
        .wdata_i  (sfr_wdata_i),
        .key_ok_o (key_ok_w)
    );

    // Machine cycle enable from the oscillator clock
    // Free-running from reset, so the first count step after a key
    // lands anywhere within one machine cycle
    // R16: divider holds in power-down, like a stopped oscillator
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mc_div_q <= '0;
        end else if (power_down_i) begin
            // Frozen, resumes where it stopped
            mc_div_q <= mc_div_q;
        end else if (mc_div_q == MC_OSC_PERIODS - 4'h1) begin
            mc_div_q <= '0;
        end else begin
            mc_div_q <= mc_div_q + 4'h1;
        end
    end

    // Registered tick keeps the enable glitch-free
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mc_tick_q <= 1'b0;
        end else begin
            mc_tick_q <= !power_down_i && (mc_div_q == MC_OSC_PERIODS - 4'h1);
        end
    end

    // Enable state
    // R14: off from reset until the key arrives
    // R15: no software path clears it; only overflow or rst_i does
    // Overflow beats a key landing in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_q <= 1'b0;
        end else if (ovf_w) begin
            // Own overflow acts as a device reset
            en_q <= 1'b0;
        end else if (key_ok_w) begin
            // R1: key starts the watchdog
            en_q <= 1'b1;
        end
    end

    // Timeout select field, low bits of the period register
    // R12: reset and overflow both return it to shortest timeout
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_q <= SEL_RST;
        end else if (ovf_w) begin
            sel_q <= SEL_RST;
        end else if (sel_wr_w) begin
            // Upper bits are reserved and not stored
            sel_q <= sfr_wdata_i[SEL_LSB +: SEL_W];
        end
    end

    // Terminal count mask, one bit per counter stage
    // R10: bit i set when i is below 14 plus the selection
    // A smaller select written mid-count acts at once; a count already
    // past the new limit runs on until the chain wraps
    for (genvar i = 0; i < TOTAL_W; i++) begin : g_limit
        assign limit_w[i] = (i < (BASE_W + int'(sel_q)));
    end

    // Overflow when the running count reaches the terminal count
    // R3: overflow request feeds the device reset pulse
    assign ovf_w = en_q && (count_q == limit_w);

    // Counter chain: low 14 bits base, upper 7 bits prescaler stage
    // R9: the upper stage extends the reachable timeout by 2^7
    // R7: no bus path loads or reads this count
    // Clearing while disabled keeps a stale count from surviving
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= '0;
        end else if (ovf_w || !en_q) begin
            // Idle or just overflowed: hold at zero
            count_q <= '0;
        end else if (key_ok_w) begin
            // R2: key restarts the count
            count_q <= '0;
        end else if (mc_tick_q) begin
            // R4: one step per machine cycle
            count_q <= TOTAL_W'(count_q + 1'b1);
        end
    end

    // Reset pin pulse
    // R8: fixed width in oscillator periods
    // The pin must not feed rst_i back, or the pulse cuts itself short
    reset_pulse_gen u_pulse (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (ovf_w),
        .pulse_o (reset_pin_o)
    );

    // Read data, answered one cycle after the read strobe
    // R6: restart register reads as zero, as do unmapped addresses
    // Registered so the read path never touches the count chain
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (sfr_rd_i) begin
            if (sfr_addr_i == PERIOD_SEL_ADDR) begin
                // Reserved bits read zero
                rdata_q <= {{(DATA_W - SEL_W){1'b0}}, sel_q};
            end else begin
                rdata_q <= '0;
            end
        end
    end

    // Outputs straight from flops
    assign sfr_rdata_o = rdata_q;
    assign running_o   = en_q;

    // Checks
    // All in the oscillator domain, switched off during reset
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Reset pulse shape: high 96 cycles then low
    sequence s_pulse_96;
        reset_pin_o ##95 reset_pin_o ##1 !reset_pin_o;
    endsequence

    // Restart taken: running and count back at zero
    sequence s_restarted;
        en_q && (count_q == '0);
    endsequence

    a_key_enables: assert property ( // R1
        key_ok_w && !ovf_w |=> s_restarted)
        else $error("Completed key did not start the watchdog");

    a_key_clears: assert property ( // R2
        en_q && key_ok_w && !ovf_w |=> count_q == '0)
        else $error("Key did not clear the running count");

    a_count_bound: assert property ( // R3
        count_q <= limit_w)
        else $error("Count passed the terminal count");

    a_count_step: assert property ( // R4
        en_q && mc_tick_q && !ovf_w && !key_ok_w
        |=> count_q == TOTAL_W'($past(count_q) + 1'b1))
        else $error("Count did not advance on machine cycle");

    a_count_hold: assert property ( // R4
        en_q && !mc_tick_q && !ovf_w && !key_ok_w |=> $stable(count_q))
        else $error("Count moved without a machine cycle");

    a_restart_rd: assert property ( // R6
        sfr_rd_i && (sfr_addr_i == RESTART_KEY_ADDR) |=> sfr_rdata_o == '0)
        else $error("Restart register read returned data");

    a_pulse_width: assert property ( // R8
        ovf_w |=> s_pulse_96)
        else $error("Reset pulse not exactly 96 periods");

    a_ovf_base: assert property ( // R10
        ovf_w && (sel_q == SEL_RST) |-> count_q == 21'h003fff)
        else $error("Shortest timeout not at 16383 cycles");

    a_ovf_longest: assert property ( // R10
        ovf_w && (sel_q == 3'h7) |-> count_q == 21'h1fffff)
        else $error("Longest timeout not at full chain");

    a_sel_readback: assert property ( // R12
        sfr_rd_i && (sfr_addr_i == PERIOD_SEL_ADDR)
        |=> sfr_rdata_o == {5'h00, $past(sel_q)})
        else $error("Period register read mismatch");

    a_idle_quiet: assert property ( // R14
        !en_q |-> count_q == '0 && !ovf_w)
        else $error("Disabled watchdog is counting");

    a_no_disable: assert property ( // R15
        en_q && !ovf_w |=> en_q)
        else $error("Watchdog stopped without overflow");

    a_ovf_stops: assert property ( // R15
        ovf_w |=> !en_q && sel_q == SEL_RST)
        else $error("Overflow did not disable the watchdog");

    a_pd_freeze: assert property ( // R16
        power_down_i |=> !mc_tick_q)
        else $error("Machine cycle ticked in power-down");

    a_tick_space: assert property ( // R4
        mc_tick_q |=> !mc_tick_q [*8])
        else $error("Machine cycle ticks too close");

    // Twelve awake cycles counted from a tick
    sequence s_awake_12;
        (!power_down_i) [*8] ##1 (!power_down_i) [*4];
    endsequence

    // R4: machine cycle length
    a_tick_period: assert property ( // R4
        mc_tick_q ##0 s_awake_12 |=> mc_tick_q)
        else $error("Machine cycle not twelve clocks long");

    // R16: power-down holds count
    a_pd_count: assert property ( // R16
        (en_q && power_down_i && !ovf_w) ##1 (!key_ok_w && !ovf_w) |=> $stable(count_q))
        else $error("Count advanced in power-down");

    // R6: read data stands
    a_rdata_hold: assert property ( // R6
        !sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("Read data changed without a read");

    // R7: other reads empty
    a_unmapped_rd: assert property ( // R7
        sfr_rd_i && (sfr_addr_i != PERIOD_SEL_ADDR) |=> sfr_rdata_o == '0)
        else $error("Read away from the period register returned data");

    // R10: select write lands
    a_sel_write: assert property ( // R10
        sel_wr_w && !ovf_w |=> sel_q == $past(sfr_wdata_i[SEL_LSB +: SEL_W]))
        else $error("Period register write did not land");

    // R10: select holds otherwise
    a_sel_keep: assert property ( // R10
        !sel_wr_w && !ovf_w |=> $stable(sel_q))
        else $error("Select field moved without a write");

    // R14: stays off unkeyed
    a_stay_off: assert property ( // R14
        !en_q && !key_ok_w |=> !en_q)
        else $error("Watchdog started without a key");

    // R3: overflow raises pin
    a_pin_start: assert property ( // R3
        ovf_w |=> reset_pin_o && !running_o && (count_q == '0))
        else $error("Overflow did not raise the reset pin");

endmodule

// [verif/sfr_core_model.sv]
// Processor core model driving the special function register bus
module sfr_core_model (
    // Clock
    input  wire logic                       clk_i,
    // Register bus towards the watchdog
    output logic      [wdt_pkg::ADDR_W-1:0] addr_o,
    output logic                            wr_o,
    output logic                            rd_o,
    output logic      [wdt_pkg::DATA_W-1:0] wdata_o,
    input  wire logic [wdt_pkg::DATA_W-1:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ns;
    import wdt_pkg::*;

    // Idle bus at time zero
    initial begin
        addr_o  = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 8'h00;
    end

    // One write strobe; address and data flip afterwards, nothing is held
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o  = a;
        wdata_o = d;
        wr_o    = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o    = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
    endtask

    // One read strobe, data taken after the following edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o   = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o   = 1'b0;
        addr_o = ~a;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask

    task automatic send_key();
        write_reg(RESTART_KEY_ADDR, KEY_FIRST);
        write_reg(RESTART_KEY_ADDR, KEY_SECOND);
    endtask
endmodule

// [verif/watchdog_timer_tb_top.sv]
// Self-checking bench for the watchdog timer block
module watchdog_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import wdt_pkg::*;

    // Ceiling far above the fewer than two hundred cycles the tests need
    localparam int LIMIT = 20000;

    logic       clk_i;        // Oscillator clock
    logic       rst_i;        // Asynchronous reset
    logic [7:0] sfr_addr;     // Bus address from core model
    logic       sfr_wr;       // Write strobe
    logic       sfr_rd;       // Read strobe
    logic [7:0] sfr_wdata;    // Write data
    logic [7:0] sfr_rdata_o;  // Read data
    logic       power_down;   // Power-down level
    logic       reset_pin_o;  // Reset pin drive
    logic       running_o;    // Enable status
    logic       pin_seen;     // Sticky: reset pin ever high
    int         num_errors;   // Mismatches
    int         checks_done;  // Comparisons
    int         cycles;       // Hang guard

    watchdog_timer watchdog_timer_i (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .sfr_addr_i  (sfr_addr),
        .sfr_wr_i    (sfr_wr),
        .sfr_rd_i    (sfr_rd),
        .sfr_wdata_i (sfr_wdata),
        .sfr_rdata_o (sfr_rdata_o),
        .power_down_i(power_down),
        .reset_pin_o (reset_pin_o),
        .running_o   (running_o)
    );

    sfr_core_model sfr_core_model_i (
        .clk_i  (clk_i),
        .addr_o (sfr_addr),
        .wr_o   (sfr_wr),
        .rd_o   (sfr_rd),
        .wdata_o(sfr_wdata),
        .rdata_i(sfr_rdata_o)
    );

    // 100 ns clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // No test comes near a timeout, so any pin pulse is a fault
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (reset_pin_o === 1'b1) begin
            pin_seen <= 1'b1;
        end
        if (cycles == LIMIT) begin
            num_errors++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Reset state, restart register and select field reads
    task automatic t_reset_state();
        logic [7:0] r;
        check("running", {7'h0, running_o}, 8'h00);
        check("pin", {7'h0, reset_pin_o}, 8'h00);
        sfr_core_model_i.read_reg(PERIOD_SEL_ADDR, r);
        check("period_reset", r, 8'h00);
        sfr_core_model_i.write_reg(RESTART_KEY_ADDR, 8'h5a);
        sfr_core_model_i.read_reg(RESTART_KEY_ADDR, r);
        check("restart_read", r, 8'h00);
        $display("test reset_state done");
    endtask

    // Every select code, reserved bits kept as read
    task automatic t_period();
        logic [7:0] r;
        for (int n = 0; n < 8; n++) begin
            sfr_core_model_i.read_reg(PERIOD_SEL_ADDR, r);
            sfr_core_model_i.write_reg(PERIOD_SEL_ADDR, {r[7:3], n[2:0]});
            sfr_core_model_i.read_reg(PERIOD_SEL_ADDR, r);
            check("period_sel", r, {5'h00, n[2:0]});
        end
        sfr_core_model_i.write_reg(PERIOD_SEL_ADDR, {r[7:3], 3'h0});
        sfr_core_model_i.read_reg(8'h10, r);
        check("unmapped", r, 8'h00);
        $display("test period done");
    endtask

    // Broken keys are refused, a re-armed key with a foreign write between works
    task automatic t_key();
        sfr_core_model_i.write_reg(RESTART_KEY_ADDR, KEY_SECOND);
        sfr_core_model_i.write_reg(RESTART_KEY_ADDR, KEY_FIRST);
        sfr_core_model_i.write_reg(RESTART_KEY_ADDR, 8'h55);
        sfr_core_model_i.write_reg(RESTART_KEY_ADDR, KEY_SECOND);
        repeat (3) @(posedge clk_i);
        #1;
        check("bad_key", {7'h0, running_o}, 8'h00);
        sfr_core_model_i.write_reg(RESTART_KEY_ADDR, KEY_FIRST);
        sfr_core_model_i.write_reg(RESTART_KEY_ADDR, KEY_FIRST);
        sfr_core_model_i.write_reg(PERIOD_SEL_ADDR, 8'h00);
        sfr_core_model_i.write_reg(RESTART_KEY_ADDR, KEY_SECOND);
        check("key_c2", {7'h0, running_o}, 8'h00);
        repeat (2) @(posedge clk_i);
        #1;
        check("key_c3", {7'h0, running_o}, 8'h01);
        $display("test key done");
    endtask

    // Software cannot stop a running watchdog; power-down only freezes it
    task automatic t_no_disable();
        sfr_core_model_i.write_reg(RESTART_KEY_ADDR, 8'h00);
        sfr_core_model_i.write_reg(PERIOD_SEL_ADDR, 8'h05);
        power_down = 1'b1;
        repeat (50) @(posedge clk_i);
        #1;
        check("pd_running", {7'h0, running_o}, 8'h01);
        power_down = 1'b0;
        repeat (3) sfr_core_model_i.send_key();
        check("still_running", {7'h0, running_o}, 8'h01);
        check("no_pulse", {7'h0, pin_seen}, 8'h00);
        $display("test no_disable done");
    endtask

    // Mid-run reset disables and restores the select field
    task automatic t_mid_reset();
        logic [7:0] r;
        @(posedge clk_i);
        #1;
        rst_i = 1'b1;
        #1;
        check("rst_running", {7'h0, running_o}, 8'h00);
        @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        sfr_core_model_i.read_reg(PERIOD_SEL_ADDR, r);
        check("rst_period", r, 8'h00);
        check("rst_stays_off", {7'h0, running_o}, 8'h00);
        $display("test mid_reset done");
    endtask

    // Main sequence
    initial begin
        rst_i       = 1'b1;
        power_down  = 1'b0;
        pin_seen    = 1'b0;
        num_errors  = 0;
        checks_done = 0;
        cycles      = 0;
        repeat (4) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        t_reset_state();
        t_period();
        t_key();
        t_no_disable();
        t_mid_reset();
        summarize();
    end
endmodule
